/* File: mq_flag_params.svh */
`ifndef MQ_FLAG_PARAMS_SVH
`define MQ_FLAG_PARAMS_SVH

// ======================================================
// geometry
`define NUM_QUEUES     32
`define QUEUE_AW       5
`define QUAD_WIDTH     8

// ======================================================
// apb register offsets (byte addresses)
`define ADDR_CFG       8'h00
`define ADDR_CTRL      8'h04
`define ADDR_STAT      8'h08

// ======================================================
// control register fields and reset value
`define CTRL_RD_OE     0
`define CTRL_WR_OE     1
`define CTRL_RESET     2'h3

// ======================================================
// config register fields
`define CFG_IN_W_LSB   0
`define CFG_OUT_W_LSB  2
`define CFG_PACKET     4
`define CFG_POLLED     5
`define CFG_ERR        6
`define CFG_IN_MRS     7

// ======================================================
// status register fields
`define STAT_RD_QUAD   0
`define STAT_WR_QUAD   2
`define STAT_RD_SEL    4
`define STAT_WR_SEL    9

`endif

/* File: mq_flag_pkg.sv */
package mq_flag_pkg;

   // ======================================================
   // port width codes
   typedef enum logic [1:0] {
      W9  = 2'b00,
      W18 = 2'b01,
      W36 = 2'b10
   } width_t;

   // ======================================================
   // configuration caught during master reset
   typedef struct packed {
      width_t in_w;
      width_t out_w;
      logic   packet;
      logic   polled;
      logic   cfg_err;
   } cfg_t;

   // ======================================================
   // apb request from the master
   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [7:0]  paddr;
      logic [31:0] pwdata;
   } apb_req_t;

endpackage

/* File: mq_flag_status.sv */
`timescale 1ns/100ps
`include "mq_flag_params.svh"
module mq_flag_status
   import mq_flag_pkg::*;
#(
   parameter int QUEUE_AW = `QUEUE_AW
) (
   input  wire logic                   clk,
   input  wire logic                   rst,
   input  wire apb_req_t               apb,
   output logic [31:0]                 prdata,
   output logic                        pready,
   output logic                        pslverr,
   input  wire logic                   master_reset_n,
   input  wire logic                   out_width_sel,
   input  wire logic                   in_width_sel,
   input  wire logic                   bus_match_sel,
   input  wire logic                   packet_mode_sel,
   input  wire logic                   flag_bus_mode_sel,
   input  wire logic                   io_hstl_sel,
   input  wire logic                   write_input_powerdown,
   input  wire logic [QUEUE_AW-1:0]    rd_queue_addr,
   input  wire logic                   rd_addr_enable,
   input  wire logic                   rd_flag_strobe,
   input  wire logic [QUEUE_AW-1:0]    wr_queue_addr,
   input  wire logic                   wr_addr_enable,
   input  wire logic                   wr_flag_strobe,
   input  wire logic [2**QUEUE_AW-1:0] queue_almost_empty,
   input  wire logic [2**QUEUE_AW-1:0] queue_almost_full,
   input  wire logic [2**QUEUE_AW-1:0] queue_packet_ready,
   output logic                        rd_almost_empty_n,
   output logic                        packet_ready_n,
   output logic [7:0]                  rd_quadrant_flag_bus,
   output logic                        rd_flag_bus_oe,
   output logic [QUEUE_AW-4:0]         rd_bus_quadrant,
   output logic                        wr_almost_full_n,
   output logic [7:0]                  wr_quadrant_flag_bus,
   output logic                        wr_flag_bus_oe,
   output logic [QUEUE_AW-4:0]         wr_bus_quadrant,
   output logic                        write_data_in_enable
);

   localparam int NQ  = 2**QUEUE_AW;
   localparam int QAW = QUEUE_AW - 3;

   cfg_t                cfg;
   logic [1:0]          ctrl;
   logic [QUEUE_AW-1:0] rd_sel;
   logic [QUEUE_AW-1:0] wr_sel;
   logic [QAW-1:0]      rd_ptr;
   logic [QAW-1:0]      wr_ptr;
   logic [QAW-1:0]      next_rd_quad;
   logic [QAW-1:0]      next_wr_quad;
   logic [NQ-1:0]       rd_src;
   logic                apb_access;

   // ======================================================
   // helpers
   function automatic logic [7:0] quad_slice(input logic [NQ-1:0] v, input logic [QAW-1:0] q);
      return v[{q, 3'b000} +: 8];
   endfunction

   function automatic cfg_t decode_cfg(input logic bm, input logic iw, input logic ow,
                                       input logic pkt, input logic fm);
      cfg_t c;
      c.in_w  = W36;
      c.out_w = W36;
      if (bm) begin
         if (iw) begin
            c.in_w = ow ? W9 : W18;
         end else begin
            c.out_w = ow ? W9 : W18;
         end
      end
      c.packet  = pkt && (c.in_w == W36) && (c.out_w == W36);
      c.cfg_err = pkt && !c.packet;
      c.polled  = fm;
      return c;
   endfunction

   // ======================================================
   // configuration sampled during master reset
   // catch widths and mode
   always_ff @(posedge clk) begin
      if (rst) begin
         cfg <= '{in_w: W36, out_w: W36, default: 1'b0};
      end else if (!master_reset_n) begin
         cfg <= decode_cfg(bus_match_sel, in_width_sel, out_width_sel, packet_mode_sel, flag_bus_mode_sel);
      end
   end

   // ======================================================
   // queue selection
   always_ff @(posedge clk) begin
      if (rst || !master_reset_n) begin
         rd_sel <= '0;
      end else if (rd_addr_enable) begin
         rd_sel <= rd_queue_addr;
      end
   end

   always_ff @(posedge clk) begin
      if (rst || !master_reset_n) begin
         wr_sel <= '0;
      end else if (wr_addr_enable) begin
         wr_sel <= wr_queue_addr;
      end
   end

   // ======================================================
   // discrete flags
   // selected read queue flags
   always_ff @(posedge clk) begin
      if (rst || !master_reset_n) begin
         rd_almost_empty_n <= 1'b1;
         packet_ready_n    <= 1'b1;
      end else begin
         rd_almost_empty_n <= !queue_almost_empty[rd_sel];
         packet_ready_n    <= !(cfg.packet && queue_packet_ready[rd_sel]);
      end
   end

   always_ff @(posedge clk) begin
      if (rst || !master_reset_n) begin
         wr_almost_full_n <= 1'b1;
      end else begin
         wr_almost_full_n <= !queue_almost_full[wr_sel];
      end
   end

   // ======================================================
   // polled quadrant pointers
   // ascend from first
   always_ff @(posedge clk) begin
      if (rst || !master_reset_n) begin
         rd_ptr <= '0;
      end else begin
         rd_ptr <= rd_ptr + 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst || !master_reset_n) begin
         wr_ptr <= '0;
      end else begin
         wr_ptr <= wr_ptr + 1'b1;
      end
   end

   // ======================================================
   // quadrant choice for each bus
   // direct or polled read
   always_comb begin
      next_rd_quad = rd_bus_quadrant;
      if (cfg.polled) begin
         next_rd_quad = rd_ptr;
      end else if (rd_flag_strobe) begin
         next_rd_quad = rd_queue_addr[QUEUE_AW-1:3];
      end
   end

   always_comb begin
      next_wr_quad = wr_bus_quadrant;
      if (cfg.polled) begin
         next_wr_quad = wr_ptr;
      end else if (wr_flag_strobe) begin
         next_wr_quad = wr_queue_addr[QUEUE_AW-1:3];
      end
   end

   assign rd_src = cfg.packet ? queue_packet_ready : queue_almost_empty;

   // ======================================================
   // flag buses
   // eight-bit read bus
   always_ff @(posedge clk) begin
      if (rst || !master_reset_n) begin
         rd_bus_quadrant      <= '0;
         rd_quadrant_flag_bus <= 8'hff;
      end else begin
         rd_bus_quadrant      <= next_rd_quad;
         rd_quadrant_flag_bus <= ~quad_slice(rd_src, next_rd_quad);
      end
   end

   always_ff @(posedge clk) begin
      if (rst || !master_reset_n) begin
         wr_bus_quadrant      <= '0;
         wr_quadrant_flag_bus <= 8'hff;
      end else begin
         wr_bus_quadrant      <= next_wr_quad;
         wr_quadrant_flag_bus <= ~quad_slice(queue_almost_full, next_wr_quad);
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         rd_flag_bus_oe <= 1'b0;
         wr_flag_bus_oe <= 1'b0;
      end else begin
         rd_flag_bus_oe <= master_reset_n && ctrl[`CTRL_RD_OE];
         wr_flag_bus_oe <= master_reset_n && ctrl[`CTRL_WR_OE];
      end
   end

   // ======================================================
   // write input power-down
   // hstl only gate
   always_ff @(posedge clk) begin
      if (rst) begin
         write_data_in_enable <= 1'b1;
      end else begin
         write_data_in_enable <= !(io_hstl_sel && write_input_powerdown);
      end
   end

   // ======================================================
   // apb slave, one wait state
   assign apb_access = apb.psel && apb.penable;

   always_ff @(posedge clk) begin
      if (rst) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= '0;
      end else begin
         pready  <= apb_access && !pready;
         pslverr <= 1'b0;
         prdata  <= '0;
         if (apb_access && !pready) begin
            if (apb.paddr == `ADDR_CFG) begin
               prdata[`CFG_IN_W_LSB +: 2]  <= cfg.in_w;
               prdata[`CFG_OUT_W_LSB +: 2] <= cfg.out_w;
               prdata[`CFG_PACKET]         <= cfg.packet;
               prdata[`CFG_POLLED]         <= cfg.polled;
               prdata[`CFG_ERR]            <= cfg.cfg_err;
               prdata[`CFG_IN_MRS]         <= !master_reset_n;
            end else if (apb.paddr == `ADDR_CTRL) begin
               prdata[1:0] <= ctrl;
            end else if (apb.paddr == `ADDR_STAT) begin
               prdata[`STAT_RD_QUAD +: QAW]     <= rd_bus_quadrant;
               prdata[`STAT_WR_QUAD +: QAW]     <= wr_bus_quadrant;
               prdata[`STAT_RD_SEL +: QUEUE_AW] <= rd_sel;
               prdata[`STAT_WR_SEL +: QUEUE_AW] <= wr_sel;
            end else begin
               pslverr <= 1'b1;
            end
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         ctrl <= `CTRL_RESET;
      end else if (apb_access && pready && apb.pwrite && apb.paddr == `ADDR_CTRL) begin
         ctrl <= apb.pwdata[1:0];
      end
   end

   // ======================================================
   // checks
   property p_rd_ae_sel;
      @(posedge clk) disable iff (rst)
      (master_reset_n && rd_addr_enable) ##1 (master_reset_n && !rd_addr_enable) |=>
         rd_almost_empty_n == !$past(queue_almost_empty[rd_queue_addr], 2) || !$past(master_reset_n);
   endproperty
   a_rd_ae_sel: assert property (p_rd_ae_sel) else $error("almost-empty wrong queue");

   property p_wr_af_sel;
      @(posedge clk) disable iff (rst)
      (master_reset_n && wr_addr_enable) ##1 (master_reset_n && !wr_addr_enable) |=>
         wr_almost_full_n == !$past(queue_almost_full[wr_queue_addr], 2) || !$past(master_reset_n);
   endproperty
   a_wr_af_sel: assert property (p_wr_af_sel) else $error("almost-full wrong queue");

   property p_rd_poll;
      @(posedge clk) disable iff (rst)
      (master_reset_n && cfg.polled) ##1 (master_reset_n && cfg.polled) |=>
         rd_bus_quadrant == QAW'($past(rd_bus_quadrant) + 1'b1);
   endproperty
   a_rd_poll: assert property (p_rd_poll) else $error("read poll did not advance");

   property p_wr_poll;
      @(posedge clk) disable iff (rst)
      (master_reset_n && cfg.polled) ##1 (master_reset_n && cfg.polled) |=>
         wr_bus_quadrant == QAW'($past(wr_bus_quadrant) + 1'b1);
   endproperty
   a_wr_poll: assert property (p_wr_poll) else $error("write poll did not advance");

   property p_poll_start;
      @(posedge clk) disable iff (rst)
      !master_reset_n ##1 master_reset_n |=> rd_bus_quadrant == '0 && wr_bus_quadrant == '0;
   endproperty
   a_poll_start: assert property (p_poll_start) else $error("poll start not first quadrant");

   property p_rd_direct;
      @(posedge clk) disable iff (rst)
      (master_reset_n && !cfg.polled && rd_flag_strobe) ##1 (master_reset_n && !rd_flag_strobe) |->
         ##1 rd_bus_quadrant == $past(rd_queue_addr[QUEUE_AW-1:3], 2);
   endproperty
   a_rd_direct: assert property (p_rd_direct) else $error("read bus wrong quadrant");

   property p_pkt_width;
      @(posedge clk) disable iff (rst)
      cfg.packet |-> cfg.in_w == W36 && cfg.out_w == W36;
   endproperty
   a_pkt_width: assert property (p_pkt_width) else $error("packet mode with narrow port");

   property p_pr_idle;
      @(posedge clk) disable iff (rst)
      !cfg.packet ##1 !cfg.packet |-> packet_ready_n;
   endproperty
   a_pr_idle: assert property (p_pr_idle) else $error("packet ready outside packet mode");

   property p_pd_gate;
      @(posedge clk) disable iff (rst)
      1'b1 |=> write_data_in_enable == !($past(io_hstl_sel) && $past(write_input_powerdown));
   endproperty
   a_pd_gate: assert property (p_pd_gate) else $error("power-down gate wrong");

   property p_oe_mrs;
      @(posedge clk) disable iff (rst)
      !master_reset_n |=> !rd_flag_bus_oe && !wr_flag_bus_oe && rd_quadrant_flag_bus == 8'hff;
   endproperty
   a_oe_mrs: assert property (p_oe_mrs) else $error("flag bus driven in master reset");

endmodule

/* File: host_flag_model.sv */
`timescale 1ns/100ps
module host_flag_model
   import mq_flag_pkg::*;
(
   input  wire logic   clk,
   output logic        master_reset_n,
   output logic        out_width_sel,
   output logic        in_width_sel,
   output logic        bus_match_sel,
   output logic        packet_mode_sel,
   output logic        flag_bus_mode_sel,
   output logic [4:0]  rd_queue_addr,
   output logic        rd_addr_enable,
   output logic        rd_flag_strobe,
   output logic [4:0]  wr_queue_addr,
   output logic        wr_addr_enable,
   output logic        wr_flag_strobe,
   output logic [31:0] queue_almost_empty,
   output logic [31:0] queue_almost_full,
   output logic [31:0] queue_packet_ready
);
   // ======================================================
   // idle levels and fixed queue status patterns
   initial begin
      master_reset_n = 1'b1;
      {out_width_sel, in_width_sel, bus_match_sel} = 3'h0;
      {packet_mode_sel, flag_bus_mode_sel} = 2'h0;
      {rd_queue_addr, rd_addr_enable, rd_flag_strobe} = 7'h00;
      {wr_queue_addr, wr_addr_enable, wr_flag_strobe} = 7'h00;
      queue_almost_empty = 32'h5a3c_96e1;
      queue_almost_full = 32'hc3a5_0f71;
      queue_packet_ready = 32'h1e2d_b487;
   end

   // ======================================================
   // master reset pulse with straps
   // high low high
   task automatic mreset(input logic pkt, input logic fm, input logic bm, input logic iw, input logic ow);
      @(posedge clk);
      master_reset_n <= 1'b0;
      packet_mode_sel <= pkt;
      flag_bus_mode_sel <= fm;
      {bus_match_sel, in_width_sel, out_width_sel} <= {bm, iw, ow};
      repeat (2) @(posedge clk);
      master_reset_n <= 1'b1;
   endtask

   // ======================================================
   // queue and quadrant select on both ports
   task automatic sel(input logic [4:0] q);
      @(posedge clk);
      {rd_queue_addr, rd_addr_enable, rd_flag_strobe} <= {q, 2'b11};
      {wr_queue_addr, wr_addr_enable, wr_flag_strobe} <= {q, 2'b11};
      @(posedge clk);
      {rd_addr_enable, rd_flag_strobe, wr_addr_enable, wr_flag_strobe} <= 4'h0;
   endtask
endmodule

/* File: tb.sv */
`timescale 1ns/100ps
`include "mq_flag_params.svh"
module tb
   import mq_flag_pkg::*;
;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   apb_req_t    apb = '0;
   logic        io_hstl_sel = 1'b0;
   logic        write_input_powerdown = 1'b0;
   logic [31:0] prdata, rd, queue_almost_empty, queue_almost_full, queue_packet_ready;
   logic        pready, pslverr, er, master_reset_n, out_width_sel, in_width_sel, bus_match_sel;
   logic        packet_mode_sel, flag_bus_mode_sel, rd_addr_enable, rd_flag_strobe, wr_addr_enable;
   logic        wr_flag_strobe, rd_almost_empty_n, packet_ready_n, rd_flag_bus_oe, wr_almost_full_n;
   logic        wr_flag_bus_oe, write_data_in_enable;
   logic [4:0]  rd_queue_addr, wr_queue_addr;
   logic [7:0]  rd_quadrant_flag_bus, wr_quadrant_flag_bus;
   logic [1:0]  rd_bus_quadrant, wr_bus_quadrant;
   int          errors, tests_run, cycles, q;

   always #2.5 clk = ~clk;

   mq_flag_status #(.QUEUE_AW(5)) i_dut (.clk, .rst, .apb, .prdata, .pready, .pslverr, .master_reset_n,
      .out_width_sel, .in_width_sel, .bus_match_sel, .packet_mode_sel, .flag_bus_mode_sel, .io_hstl_sel,
      .write_input_powerdown, .rd_queue_addr, .rd_addr_enable, .rd_flag_strobe, .wr_queue_addr,
      .wr_addr_enable, .wr_flag_strobe, .queue_almost_empty, .queue_almost_full, .queue_packet_ready,
      .rd_almost_empty_n, .packet_ready_n, .rd_quadrant_flag_bus, .rd_flag_bus_oe, .rd_bus_quadrant,
      .wr_almost_full_n, .wr_quadrant_flag_bus, .wr_flag_bus_oe, .wr_bus_quadrant, .write_data_in_enable);

   host_flag_model i_host (.clk, .master_reset_n, .out_width_sel, .in_width_sel, .bus_match_sel,
      .packet_mode_sel, .flag_bus_mode_sel, .rd_queue_addr, .rd_addr_enable, .rd_flag_strobe,
      .wr_queue_addr, .wr_addr_enable, .wr_flag_strobe, .queue_almost_empty, .queue_almost_full,
      .queue_packet_ready);

   // ======================================================
   // compare, report and close
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         errors++;
         stop_test();
      end
   end

   // ======================================================
   // apb transfer, held until pready
   task automatic apb_xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
      @(posedge clk);
      apb <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr, pwdata: wd};
      @(posedge clk);
      apb.penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      apb <= '0;
   endtask

   task automatic settle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   // ======================================================
   // main sequence
   initial begin
      settle(7);
      check("rd_oe", rd_flag_bus_oe, 1'b0);
      check("rd_bus", rd_quadrant_flag_bus, 8'hff);
      check("rd_quad", rd_bus_quadrant, 2'h0);
      @(posedge clk);
      rst <= 1'b0;
      i_host.mreset(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
      apb_xfer(1'b0, `ADDR_CFG, 32'h0);
      check("cfg", rd, 32'h1a);
      apb_xfer(1'b1, `ADDR_CFG, 32'hff);
      apb_xfer(1'b0, `ADDR_CFG, 32'h0);
      check("cfg_ro", rd, 32'h1a);
      apb_xfer(1'b0, `ADDR_CTRL, 32'h0);
      check("ctrl", rd, 32'h3);
      apb_xfer(1'b0, 8'h0c, 32'h0);
      check("unmapped_err", er, 1'b1);
      for (q = 0; q < 32; q += 9) begin
         i_host.sel(q[4:0]);
         settle(3);
         check("ae_n", rd_almost_empty_n, !queue_almost_empty[q]);
         check("pr_n", packet_ready_n, !queue_packet_ready[q]);
         check("rd_bus", rd_quadrant_flag_bus, queue_packet_ready[q/9*8 +: 8] ^ 8'hff);
         check("rd_quad", rd_bus_quadrant, q / 9);
         check("af_n", wr_almost_full_n, !queue_almost_full[q]);
         check("wr_bus", wr_quadrant_flag_bus, queue_almost_full[q/9*8 +: 8] ^ 8'hff);
         check("oe", {rd_flag_bus_oe, wr_flag_bus_oe}, 2'b11);
      end
      apb_xfer(1'b0, `ADDR_STAT, 32'h0);
      check("stat", rd, 32'h37bf);
      apb_xfer(1'b1, `ADDR_CTRL, 32'h0);
      settle(2);
      check("oe_off", {rd_flag_bus_oe, wr_flag_bus_oe}, 2'b00);
      apb_xfer(1'b1, `ADDR_CTRL, 32'h3);
      for (q = 0; q < 4; q++) begin
         @(posedge clk);
         {io_hstl_sel, write_input_powerdown} <= q[1:0];
         settle(2);
         check("wr_in_en", write_data_in_enable, q != 3);
      end
      i_host.mreset(1'b1, 1'b1, 1'b1, 1'b0, 1'b0);
      for (q = 0; q < 6; q++) begin
         settle(1);
         check("rd_quad", rd_bus_quadrant, q % 4);
         check("rd_bus", rd_quadrant_flag_bus, queue_almost_empty[q%4*8 +: 8] ^ 8'hff);
         check("wr_quad", wr_bus_quadrant, q % 4);
         check("wr_bus", wr_quadrant_flag_bus, queue_almost_full[q%4*8 +: 8] ^ 8'hff);
      end
      check("ae_n", rd_almost_empty_n, !queue_almost_empty[0]);
      check("pr_n", packet_ready_n, 1'b1);
      apb_xfer(1'b0, `ADDR_CFG, 32'h0);
      check("cfg", rd, 32'h66);
      i_host.mreset(1'b0, 1'b0, 1'b1, 1'b1, 1'b1);
      apb_xfer(1'b0, `ADDR_CFG, 32'h0);
      check("cfg_w9", rd, 32'h08);
      stop_test();
   end
endmodule
